/* design/acir_top.sv */
`timescale 1ns/1ps
`include "acir_consts.svh"
module acir_top import acir_pkg::*; #(
    parameter int FAST_STEP_CYCLES =
        `ACIR_RAMP_FAST_STEP_NS / `ACIR_REF_CLK_PERIOD_NS,
    parameter int SLOW_RATIO = `ACIR_RAMP_SLOW_RATIO,
    parameter int THRESH_UNIT = `ACIR_RAMP_THRESH_UNIT
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire acir_reg_req_t reg_req_in,
    input wire logic output_stage_powerdown_in,
    input wire logic [1:0] ramp_threshold_in,
    input wire logic gain_up_done_in,
    input wire logic gain_down_done_in,
    input wire logic jack_detect_in,
    input wire logic output_short_in,
    input wire logic [4:0] input_gain_left_in,
    input wire logic [4:0] input_gain_right_in,
    output logic [7:0] reg_rdata_out,
    output logic mic_input_powerdown_out,
    output logic mixer_to_adc_powerdown_out,
    output logic output_load_type_select_out,
    output logic complete_standby_out,
    output logic sleep_select_out,
    output logic [7:0] ramp_level_out,
    output acir_gains_t gains_out,
    output logic irq_out
);
    localparam int NREGS = 13;

    acir_top_regs_t s;
    acir_top_regs_t next_s;
    logic ramp_up_done;
    logic ramp_down_done;
    logic in_range;
    logic [3:0] idx;
    logic [7:0] mask;
    logic [5:0] evt;
    logic [5:0] clr;
    logic [5:0] pend;
    logic [5:0] fresh;
    logic [7:0] interrupt_control;
    logic active;

    function automatic logic [3:0] slot(input logic [4:0] ofs);
        return 4'(ofs - `ACIR_OFS_FIRST);
    endfunction

    // slots 07 and 09 hold no writable bits; flags live apart
    function automatic logic [7:0] write_mask(input logic [3:0] i);
        logic [4:0] a;
        a = 5'(i) + `ACIR_OFS_FIRST;
        case (a)
            `ACIR_OFS_POWER_MODE_TWO,
            `ACIR_OFS_INTERRUPT_CONTROL,
            `ACIR_OFS_DAC_MIX_GAIN: return `ACIR_MASK_FULL;
            `ACIR_OFS_LINE_ONE_LEFT,
            `ACIR_OFS_LINE_TWO_LEFT,
            `ACIR_OFS_MIC_LEFT,
            `ACIR_OFS_OUTSTAGE_LEFT: return `ACIR_MASK_LEFT_GAIN;
            `ACIR_OFS_LINE_ONE_RIGHT,
            `ACIR_OFS_LINE_TWO_RIGHT,
            `ACIR_OFS_MIC_RIGHT,
            `ACIR_OFS_OUTSTAGE_RIGHT: return `ACIR_MASK_RIGHT_GAIN;
            default: return `ACIR_MASK_NONE;
        endcase
    endfunction

    function automatic logic [7:0] reset_value(input logic [3:0] i);
        logic [4:0] a;
        a = 5'(i) + `ACIR_OFS_FIRST;
        case (a)
            `ACIR_OFS_POWER_MODE_TWO: return `ACIR_RST_POWER_MODE_TWO;
            `ACIR_OFS_INTERRUPT_CONTROL:
                return `ACIR_RST_INTERRUPT_CONTROL;
            `ACIR_OFS_DAC_MIX_GAIN: return `ACIR_RST_DAC_MIX_GAIN;
            `ACIR_OFS_OUTSTAGE_LEFT,
            `ACIR_OFS_OUTSTAGE_RIGHT: return `ACIR_RST_OUTSTAGE_GAIN;
            `ACIR_OFS_LINE_ONE_LEFT,
            `ACIR_OFS_LINE_ONE_RIGHT,
            `ACIR_OFS_LINE_TWO_LEFT,
            `ACIR_OFS_LINE_TWO_RIGHT,
            `ACIR_OFS_MIC_LEFT,
            `ACIR_OFS_MIC_RIGHT: return `ACIR_RST_MIX_GAIN;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] gain_reg(
        input acir_top_regs_t st,
        input logic [4:0] ofs
    );
        return st.regs[slot(ofs)];
    endfunction

    function automatic acir_top_regs_t reset_state();
        acir_top_regs_t v;
        v = '0;
        for (int i = 0; i < NREGS; i++)
        begin
            v.regs[i] = reset_value(4'(i));
        end
        return v;
    endfunction

    acir_ramp #(
        .FAST_STEP_CYCLES(FAST_STEP_CYCLES),
        .SLOW_RATIO(SLOW_RATIO),
        .THRESH_UNIT(THRESH_UNIT)
    ) u_ramp (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .powerdown_in(output_stage_powerdown_in),
        .threshold_in(ramp_threshold_in),
        .level_out(ramp_level_out),
        .up_done_out(ramp_up_done),
        .down_done_out(ramp_down_done)
    );

    always_comb
    begin
        next_s = s;
        interrupt_control = gain_reg(s, `ACIR_OFS_INTERRUPT_CONTROL);
        in_range = (reg_req_in.addr >= `ACIR_OFS_FIRST) &&
            (reg_req_in.addr <= `ACIR_OFS_LAST);
        idx = slot(reg_req_in.addr);
        mask = in_range ? write_mask(idx) : `ACIR_MASK_NONE;

        // pins: two flops before anything looks at them
        next_s.jack_s1 = jack_detect_in;
        next_s.jack_s2 = s.jack_s1;
        next_s.jack_q = s.jack_s2;
        next_s.short_s1 = output_short_in;
        next_s.short_s2 = s.short_s1;

        evt = {s.jack_s2 ^ s.jack_q,
            1'b0,
            ramp_up_done, ramp_down_done,
            gain_up_done_in, gain_down_done_in};
        clr = 6'h00;
        if (reg_req_in.wr &&
            reg_req_in.addr == `ACIR_OFS_INTERRUPT_FLAGS)
        begin
            clr = reg_req_in.wdata[5:0] & `ACIR_FLAG_W1C_MASK;
        end
        // set beats clear; masks never gate flag setting
        next_s.flags = (s.flags & ~clr) | evt;

        if (reg_req_in.wr && in_range)
        begin
            next_s.regs[idx] = (s.regs[idx] & ~mask) |
                (reg_req_in.wdata & mask);
        end

        pend = {s.flags[5], s.short_s2, s.flags[3:0]} & ~interrupt_control[5:0];
        fresh = pend & ~s.pend_q;
        next_s.pend_q = pend;
        if (|fresh)
        begin
            next_s.pulse_cnt = `ACIR_IRQ_PULSE_CYCLES;
        end
        else if (s.pulse_cnt != 4'h0)
        begin
            next_s.pulse_cnt = s.pulse_cnt - 4'h1;
        end
        if (interrupt_control[`ACIR_BIT_IRQ_PULSE])
        begin
            active = next_s.pulse_cnt != 4'h0;
        end
        else
        begin
            active = |pend;
        end
        next_s.irq = active ^ interrupt_control[`ACIR_BIT_IRQ_LOW];

        // slices taken on the register array; a call result has no select
        next_s.gains.input_amp = acir_couple(
            s.regs[slot(`ACIR_OFS_POWER_MODE_TWO)][7:6],
            input_gain_left_in, input_gain_right_in);
        next_s.gains.dacmix = acir_couple(
            s.regs[slot(`ACIR_OFS_POWER_MODE_TWO)][5:4],
            {1'b0, s.regs[slot(`ACIR_OFS_DAC_MIX_GAIN)][3:0]},
            {1'b0, s.regs[slot(`ACIR_OFS_DAC_MIX_GAIN)][7:4]});
        next_s.gains.line1 = acir_couple(
            s.regs[slot(`ACIR_OFS_LINE_ONE_LEFT)][7:6],
            s.regs[slot(`ACIR_OFS_LINE_ONE_LEFT)][4:0],
            s.regs[slot(`ACIR_OFS_LINE_ONE_RIGHT)][4:0]);
        next_s.gains.line2 = acir_couple(
            s.regs[slot(`ACIR_OFS_LINE_TWO_LEFT)][7:6],
            s.regs[slot(`ACIR_OFS_LINE_TWO_LEFT)][4:0],
            s.regs[slot(`ACIR_OFS_LINE_TWO_RIGHT)][4:0]);
        next_s.gains.mic = acir_couple(
            s.regs[slot(`ACIR_OFS_MIC_LEFT)][7:6],
            s.regs[slot(`ACIR_OFS_MIC_LEFT)][4:0],
            s.regs[slot(`ACIR_OFS_MIC_RIGHT)][4:0]);
        next_s.gains.outstage = acir_couple(
            s.regs[slot(`ACIR_OFS_OUTSTAGE_LEFT)][7:6],
            s.regs[slot(`ACIR_OFS_OUTSTAGE_LEFT)][4:0],
            s.regs[slot(`ACIR_OFS_OUTSTAGE_RIGHT)][4:0]);

        // read data follows the address one cycle later
        if (reg_req_in.addr == `ACIR_OFS_INTERRUPT_FLAGS)
        begin
            next_s.rdata = {1'b0, s.jack_s2, s.flags[5],
                s.short_s2, s.flags[3:0]};
        end
        else if (in_range)
        begin
            next_s.rdata = s.regs[idx] & write_mask(idx);
        end
        else
        begin
            next_s.rdata = 8'h00;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            s <= reset_state();
        end
        else
        begin
            s <= next_s;
        end
    end

    assign reg_rdata_out = s.rdata;
    assign mic_input_powerdown_out =
        s.regs[slot(`ACIR_OFS_POWER_MODE_TWO)][`ACIR_BIT_MIC_PD];
    assign mixer_to_adc_powerdown_out =
        s.regs[slot(`ACIR_OFS_POWER_MODE_TWO)][`ACIR_BIT_IND_PD];
    assign output_load_type_select_out =
        s.regs[slot(`ACIR_OFS_POWER_MODE_TWO)][`ACIR_BIT_LOAD_TYPE];
    assign complete_standby_out =
        s.regs[slot(`ACIR_OFS_POWER_MODE_TWO)][`ACIR_BIT_STANDBY];
    assign sleep_select_out =
        s.regs[slot(`ACIR_OFS_POWER_MODE_TWO)][`ACIR_BIT_SLEEP];
    assign gains_out = s.gains;
    assign irq_out = s.irq;
endmodule

/* design/acir_consts.svh */
`ifndef ACIR_CONSTS_SVH
`define ACIR_CONSTS_SVH
// Functional notes
// - power bits 1/0 drop mic, mixer-to-ADC
// - input coupling 00 split, 1x left, 01 right
// - DAC mix coupling 00 split, 10 left
// - ramp fast/slow steps, 256 steps total
// - threshold 11 holds two slow steps midway
// - irq form: level/pulse, high/low, 8 cycles
// - control bits 5..0 mask the six events
// - masked event still sets its flag
// - level irq active when flags and-not mask
// - pulse on new unmasked or unmasked pending
// - flag bit 6 shows jack presence
// - bit 5 set on jack change, write-1 clears
// - bit 4 read-only short-circuit status
// - bits 3/2 ramp up/down done, write-1 clears
// - bits 1/0 gain up/down done, write-1 clears
// - DAC mix gains right 7-4, left 3-0
// - line 1 gains 5 bit, coupling like input
// - line 2 gains 5 bit, same coupling code
// - mic sidetone gains 5 bit, same coupling
// - output stage gains 5 bit, same coupling
// - gain sequence ends set flag, raise irq
// - headphone ramp end raises irq

`define ACIR_REF_CLK_PERIOD_NS 10

`define ACIR_OFS_FIRST 5'h06
`define ACIR_OFS_LAST 5'h12
`define ACIR_OFS_POWER_MODE_TWO 5'h06
`define ACIR_OFS_INTERRUPT_CONTROL 5'h08
`define ACIR_OFS_INTERRUPT_FLAGS 5'h09
`define ACIR_OFS_DAC_MIX_GAIN 5'h0A
`define ACIR_OFS_LINE_ONE_LEFT 5'h0B
`define ACIR_OFS_LINE_ONE_RIGHT 5'h0C
`define ACIR_OFS_LINE_TWO_LEFT 5'h0D
`define ACIR_OFS_LINE_TWO_RIGHT 5'h0E
`define ACIR_OFS_MIC_LEFT 5'h0F
`define ACIR_OFS_MIC_RIGHT 5'h10
`define ACIR_OFS_OUTSTAGE_LEFT 5'h11
`define ACIR_OFS_OUTSTAGE_RIGHT 5'h12

`define ACIR_RST_POWER_MODE_TWO 8'h03
`define ACIR_RST_INTERRUPT_CONTROL 8'h3F
`define ACIR_RST_INTERRUPT_FLAGS 8'h00
`define ACIR_RST_DAC_MIX_GAIN 8'h00
`define ACIR_RST_MIX_GAIN 8'h04
`define ACIR_RST_OUTSTAGE_GAIN 8'h0A

`define ACIR_MASK_FULL 8'hFF
`define ACIR_MASK_LEFT_GAIN 8'hDF
`define ACIR_MASK_RIGHT_GAIN 8'h1F
`define ACIR_MASK_NONE 8'h00
`define ACIR_FLAG_W1C_MASK 6'h2F

`define ACIR_BIT_MIC_PD 1
`define ACIR_BIT_IND_PD 0
`define ACIR_BIT_LOAD_TYPE 2
`define ACIR_BIT_STANDBY 1
`define ACIR_BIT_SLEEP 0
`define ACIR_BIT_IRQ_PULSE 7
`define ACIR_BIT_IRQ_LOW 6
`define ACIR_BIT_JACK 6
`define ACIR_BIT_JACK_EVENT 5

`define ACIR_RAMP_FAST_STEP_NS 875000
`define ACIR_RAMP_SLOW_RATIO 2
`define ACIR_RAMP_THRESH_UNIT 16
`define ACIR_RAMP_MID_LOW 8'h7F
`define ACIR_RAMP_MID_HIGH 8'h80
`define ACIR_RAMP_HOLD_CODE 2'h3
`define ACIR_IRQ_PULSE_CYCLES 4'h8

`endif

/* design/acir_pkg.sv */
package acir_pkg;

    typedef struct packed {
        logic [4:0] left;
        logic [4:0] right;
    } acir_gain_pair_t;

    typedef struct packed {
        acir_gain_pair_t input_amp;
        acir_gain_pair_t dacmix;
        acir_gain_pair_t line1;
        acir_gain_pair_t line2;
        acir_gain_pair_t mic;
        acir_gain_pair_t outstage;
    } acir_gains_t;

    typedef struct packed {
        logic [4:0] addr;
        logic wr;
        logic [7:0] wdata;
    } acir_reg_req_t;

    typedef enum logic [1:0] {RAMP_IDLE, RAMP_RISE, RAMP_FALL}
        acir_ramp_state_t;

    // tick limited to 24 bits, enough for 2 slow steps at 100 MHz
    typedef struct packed {
        acir_ramp_state_t state;
        logic [7:0] level;
        logic [23:0] tick;
        logic pd_q;
        logic up_done;
        logic down_done;
    } acir_ramp_regs_t;

    typedef struct packed {
        logic [12:0][7:0] regs;
        logic [5:0] flags;
        logic jack_s1;
        logic jack_s2;
        logic jack_q;
        logic short_s1;
        logic short_s2;
        logic [5:0] pend_q;
        logic [3:0] pulse_cnt;
        logic irq;
        logic [7:0] rdata;
        acir_gains_t gains;
    } acir_top_regs_t;

    // code 00 split, 1x left drives both, 01 right drives both
    function automatic acir_gain_pair_t acir_couple(
        input logic [1:0] code,
        input logic [4:0] left,
        input logic [4:0] right
    );
        acir_gain_pair_t p;
        p.left = left;
        p.right = right;
        if (code[1])
        begin
            p.right = left;
        end
        else if (code[0])
        begin
            p.left = right;
        end
        return p;
    endfunction

endpackage

/* design/acir_ramp.sv */
`timescale 1ns/1ps
`include "acir_consts.svh"
module acir_ramp import acir_pkg::*; #(
    parameter int FAST_STEP_CYCLES =
        `ACIR_RAMP_FAST_STEP_NS / `ACIR_REF_CLK_PERIOD_NS,
    parameter int SLOW_RATIO = `ACIR_RAMP_SLOW_RATIO,
    parameter int THRESH_UNIT = `ACIR_RAMP_THRESH_UNIT
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic powerdown_in,
    input wire logic [1:0] threshold_in,
    output logic [7:0] level_out,
    output logic up_done_out,
    output logic down_done_out
);
    localparam logic [23:0] FAST_C = 24'(FAST_STEP_CYCLES);
    localparam logic [23:0] SLOW_C = 24'(FAST_STEP_CYCLES * SLOW_RATIO);

    acir_ramp_regs_t r;
    acir_ramp_regs_t next_r;
    logic [8:0] zone;
    logic slow;
    logic hold;
    logic [23:0] period;

    always_comb
    begin
        next_r = r;
        next_r.up_done = 1'b0;
        next_r.down_done = 1'b0;
        next_r.pd_q = powerdown_in;
        zone = 9'(int'(threshold_in) * THRESH_UNIT);
        slow = ({1'b0, r.level} >= 9'h080 - zone) &&
            ({1'b0, r.level} < 9'h080 + zone);
        hold = (threshold_in == `ACIR_RAMP_HOLD_CODE) &&
            (((r.state == RAMP_FALL) && (r.level == `ACIR_RAMP_MID_LOW)) ||
            ((r.state == RAMP_RISE) && (r.level == `ACIR_RAMP_MID_HIGH)));
        period = hold ? 24'(SLOW_C << 1) : (slow ? SLOW_C : FAST_C);
        if (powerdown_in != r.pd_q)
        begin
            // a direction change restarts from the present level
            next_r.state = powerdown_in ? RAMP_FALL : RAMP_RISE;
            next_r.tick = 24'h000000;
        end
        else
        begin
            unique case (r.state)
                RAMP_IDLE:
                begin
                    next_r.tick = 24'h000000;
                end
                RAMP_RISE:
                begin
                    if (r.tick >= period - 24'h000001)
                    begin
                        next_r.tick = 24'h000000;
                        if (r.level == 8'hFF)
                        begin
                            next_r.state = RAMP_IDLE;
                            next_r.up_done = 1'b1;
                        end
                        else
                        begin
                            next_r.level = r.level + 8'h01;
                        end
                    end
                    else
                    begin
                        next_r.tick = r.tick + 24'h000001;
                    end
                end
                RAMP_FALL:
                begin
                    if (r.tick >= period - 24'h000001)
                    begin
                        next_r.tick = 24'h000000;
                        if (r.level == 8'h00)
                        begin
                            next_r.state = RAMP_IDLE;
                            next_r.down_done = 1'b1;
                        end
                        else
                        begin
                            next_r.level = r.level - 8'h01;
                        end
                    end
                    else
                    begin
                        next_r.tick = r.tick + 24'h000001;
                    end
                end
                default:
                begin
                    next_r.state = RAMP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            r <= '{state: RAMP_IDLE, level: 8'h00, tick: 24'h000000,
                pd_q: 1'b1, up_done: 1'b0, down_done: 1'b0};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign level_out = r.level;
    assign up_done_out = r.up_done;
    assign down_done_out = r.down_done;
endmodule

/* test/acir_top_asserts.sv */
`timescale 1ns/1ps
module acir_top_asserts import acir_pkg::*; (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire acir_reg_req_t reg_req_in,
    input wire logic gain_down_done_in,
    input wire logic [4:0] input_gain_left_in,
    input wire logic [4:0] input_gain_right_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic mic_input_powerdown_out,
    input wire logic mixer_to_adc_powerdown_out,
    input wire logic [7:0] ramp_level_out,
    input wire acir_gains_t gains_out,
    input wire logic irq_out
);
    logic [7:0] interrupt_control;
    logic [7:0] pm2;
    logic [4:0] a;
    assign a = reg_req_in.addr;
    // shadow copies, so irq and coupling are judged against the bus
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            interrupt_control <= 8'h3F;
            pm2 <= 8'h03;
        end
        else if (reg_req_in.wr && a == 5'h08)
            interrupt_control <= reg_req_in.wdata;
        else if (reg_req_in.wr && a == 5'h06)
            pm2 <= reg_req_in.wdata;
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    AST_LVL_IRQ:
        assert property (gain_down_done_in && interrupt_control[7:6] == 2'b00 && !interrupt_control[0]
            |-> ##2 irq_out) else $error("level irq missing");
    AST_ALL_MASK:
        assert property (interrupt_control == 8'h3F |=> !irq_out)
            else $error("irq while all masked");
    AST_PULSE_HI:
        assert property ($rose(irq_out) && interrupt_control[7:6] == 2'b10
            |-> irq_out [*8] ##1 !irq_out) else $error("high pulse length");
    AST_PULSE_LO:
        assert property ($fell(irq_out) && interrupt_control[7:6] == 2'b11
            |-> !irq_out [*8] ##1 irq_out) else $error("low pulse length");
    AST_RD_HOLE:
        assert property (!reg_req_in.wr && (a < 5'h06 || a == 5'h07
            || a > 5'h12) |=> reg_rdata_out == 8'h00)
            else $error("unmapped read not zero");
    AST_PWR_BITS:
        assert property (reg_req_in.wr && a == 5'h06 |=>
            mic_input_powerdown_out == $past(reg_req_in.wdata[1]) &&
            mixer_to_adc_powerdown_out == $past(reg_req_in.wdata[0]))
            else $error("power bits wrong");
    AST_IN_LEFT:
        assert property (pm2[7] |=> gains_out.input_amp.right
            == $past(input_gain_left_in)) else $error("left coupling");
    AST_IN_RIGHT:
        assert property (pm2[7:6] == 2'b01 |=> gains_out.input_amp.left
            == $past(input_gain_right_in)) else $error("right coupling");
    AST_RAMP_STEP:
        assert property ($changed(ramp_level_out) |->
            ramp_level_out - $past(ramp_level_out) == 8'h01 ||
            $past(ramp_level_out) - ramp_level_out == 8'h01)
            else $error("ramp jumped");
endmodule
bind acir_top acir_top_asserts u_chk (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .reg_req_in(reg_req_in),
    .gain_down_done_in(gain_down_done_in),
    .input_gain_left_in(input_gain_left_in),
    .input_gain_right_in(input_gain_right_in),
    .reg_rdata_out(reg_rdata_out),
    .mic_input_powerdown_out(mic_input_powerdown_out),
    .mixer_to_adc_powerdown_out(mixer_to_adc_powerdown_out),
    .ramp_level_out(ramp_level_out),
    .gains_out(gains_out),
    .irq_out(irq_out)
);

/* test/acir_host.sv */
`timescale 1ns/1ps
module acir_host import acir_pkg::*; (
    input wire logic ref_clk_in,
    input wire logic [7:0] reg_rdata_in,
    output acir_reg_req_t reg_req_out
);
    initial reg_req_out = '0;
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        #1;
        reg_req_out = '{addr: a, wr: 1'b1, wdata: d};
        @(posedge ref_clk_in);
        #1;
        reg_req_out.wr = 1'b0;
        // stale data must not look valid
        reg_req_out.wdata = ~d;
    endtask
    // read data is registered: it shows one edge after the address
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        #1;
        reg_req_out.addr = a;
        @(posedge ref_clk_in);
        #1;
        d = reg_rdata_in;
    endtask
endmodule

/* test/tb_acir_top.sv */
`timescale 1ns/1ps
module tb_acir_top import acir_pkg::*;;
    localparam int FAST = 4;
    typedef struct packed {
        logic [4:0] a;
        logic [7:0] rst;
        logic [7:0] msk;
    } acir_row_t;
    acir_row_t rows [13] = '{'{5'h06, 8'h03, 8'hFF},
        '{5'h07, 8'h00, 8'h00}, '{5'h08, 8'h3F, 8'hFF},
        '{5'h0A, 8'h00, 8'hFF}, '{5'h0B, 8'h04, 8'hDF},
        '{5'h0C, 8'h04, 8'h1F}, '{5'h0D, 8'h04, 8'hDF},
        '{5'h0E, 8'h04, 8'h1F}, '{5'h0F, 8'h04, 8'hDF},
        '{5'h10, 8'h04, 8'h1F}, '{5'h11, 8'h0A, 8'hDF},
        '{5'h12, 8'h0A, 8'h1F}, '{5'h13, 8'h00, 8'h00}};
    logic [4:0] lefts [4] = '{5'h0B, 5'h0D, 5'h0F, 5'h11};
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    acir_reg_req_t req;
    logic pd = 1'b1;
    logic [1:0] th = 2'h0;
    logic gup = 1'b0;
    logic gdn = 1'b0;
    logic jack = 1'b0;
    logic shrt = 1'b0;
    logic [4:0] gl = 5'h03;
    logic [4:0] gr = 5'h1C;
    logic [7:0] rdata;
    wire [4:0] pwr;
    logic [7:0] lvl;
    acir_gains_t gains;
    logic irq;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int t0;
    int k;
    int n;

    always #5 ref_clk_in = ~ref_clk_in;

    acir_top #(.FAST_STEP_CYCLES(FAST)) u_dut (.ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in), .reg_req_in(req),
        .output_stage_powerdown_in(pd), .ramp_threshold_in(th),
        .gain_up_done_in(gup), .gain_down_done_in(gdn),
        .jack_detect_in(jack), .output_short_in(shrt),
        .input_gain_left_in(gl), .input_gain_right_in(gr),
        .reg_rdata_out(rdata), .mic_input_powerdown_out(pwr[4]),
        .mixer_to_adc_powerdown_out(pwr[3]),
        .output_load_type_select_out(pwr[2]),
        .complete_standby_out(pwr[1]), .sleep_select_out(pwr[0]),
        .ramp_level_out(lvl), .gains_out(gains), .irq_out(irq));
    acir_host u_host (.ref_clk_in(ref_clk_in), .reg_rdata_in(rdata),
        .reg_req_out(req));

    task automatic finish_test();
        $display("compared %0d errors %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp);
        n_compared++;
        if (got != exp)
        begin
            bad_count++;
            $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] v;
        u_host.rd(a, v);
        chkv(v, exp);
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic pulse(input logic up);
        tick(1);
        gup = up;
        gdn = !up;
        tick(1);
        gup = 1'b0;
        gdn = 1'b0;
    endtask
    task automatic cnt_irq(input logic v, output int c);
        c = 0;
        repeat (20)
        begin
            tick(1);
            if (irq === v)
                c++;
        end
    endtask
    // bounded, so a stuck ramp ends in a mismatch, not a hang
    task automatic wait_lvl(input logic [7:0] v, output int c);
        c = 0;
        while (lvl !== v && c < 4000)
        begin
            tick(1);
            c++;
        end
    endtask
    function automatic logic [9:0] cpl(input int c, input logic [4:0] l,
        input logic [4:0] r);
        if (c >= 2)
            return {l, l};
        if (c == 1)
            return {r, r};
        return {l, r};
    endfunction

    always @(posedge ref_clk_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            finish_test();
        end
    end

    initial
    begin
        tick(20);
        sys_rst_in = 1'b0;
        chk_rd(5'h09, 8'h00);
        foreach (rows[i])
        begin
            chk_rd(rows[i].a, rows[i].rst);
            u_host.wr(rows[i].a, 8'hFF);
            chk_rd(rows[i].a, rows[i].msk);
            u_host.wr(rows[i].a, rows[i].rst);
        end
        foreach (lefts[i])
            u_host.wr(lefts[i] + 5'h01, 8'h1A);
        u_host.wr(5'h0A, 8'h9C);
        for (k = 0; k < 4; k++)
        begin
            foreach (lefts[i])
                u_host.wr(lefts[i], {k[1:0], 6'h05});
            u_host.wr(5'h06, {k[1:0], k[1:0], 4'h3});
            tick(2);
            chkv(gains.input_amp, cpl(k, gl, gr));
            chkv(gains.dacmix, cpl(k, 5'h0C, 5'h09));
            chkv(gains.line1, cpl(k, 5'h05, 5'h1A));
            chkv(gains.line2, cpl(k, 5'h05, 5'h1A));
            chkv(gains.mic, cpl(k, 5'h05, 5'h1A));
            chkv(gains.outstage, cpl(k, 5'h05, 5'h1A));
        end
        u_host.wr(5'h06, 8'h05);
        chkv(pwr, 5'h0D);
        u_host.wr(5'h08, 8'h00);
        pulse(1'b0);
        tick(3);
        chkv(irq, 1'b1);
        pulse(1'b1);
        chk_rd(5'h09, 8'h03);
        u_host.wr(5'h09, 8'h01);
        chk_rd(5'h09, 8'h02);
        u_host.wr(5'h09, 8'h02);
        tick(3);
        chkv(irq, 1'b0);
        u_host.wr(5'h08, 8'h40);
        tick(3);
        chkv(irq, 1'b1);
        pulse(1'b1);
        tick(3);
        chkv(irq, 1'b0);
        u_host.wr(5'h09, 8'h02);
        u_host.wr(5'h08, 8'h01);
        pulse(1'b0);
        cnt_irq(1'b1, n);
        chk_n(n, 0);
        chk_rd(5'h09, 8'h01);
        u_host.wr(5'h08, 8'h80);
        cnt_irq(1'b1, n);
        chk_n(n, 8);
        u_host.wr(5'h09, 8'h01);
        u_host.wr(5'h08, 8'hC0);
        pulse(1'b1);
        cnt_irq(1'b0, n);
        chk_n(n, 8);
        u_host.wr(5'h09, 8'h02);
        u_host.wr(5'h08, 8'h3F);
        jack = 1'b1;
        shrt = 1'b1;
        tick(8);
        chk_rd(5'h09, 8'h70);
        u_host.wr(5'h09, 8'h70);
        chk_rd(5'h09, 8'h50);
        jack = 1'b0;
        shrt = 1'b0;
        tick(8);
        chk_rd(5'h09, 8'h20);
        u_host.wr(5'h09, 8'h20);
        u_host.wr(5'h08, 8'h37);
        th = 2'h3;
        pd = 1'b0;
        wait_lvl(8'h01, t0);
        wait_lvl(8'hFF, n);
        chk_n(n, 1408);
        tick(20);
        chk_rd(5'h09, 8'h08);
        chkv(irq, 1'b1);
        u_host.wr(5'h09, 8'h08);
        th = 2'h0;
        pd = 1'b1;
        wait_lvl(8'hFE, t0);
        wait_lvl(8'h00, n);
        chk_n(n, 254 * FAST);
        tick(20);
        chk_rd(5'h09, 8'h04);
        chkv(irq, 1'b0);
        u_host.wr(5'h08, 8'h00);
        pulse(1'b0);
        sys_rst_in = 1'b1;
        tick(2);
        sys_rst_in = 1'b0;
        chkv(irq, 1'b0);
        chk_rd(5'h09, 8'h00);
        chk_rd(5'h08, 8'h3F);
        finish_test();
    end
endmodule
